// ### core/flash_host_pkg.sv
// Constants, command codes and carrier types for the parallel flash host controller.
// Assumes a single 10 MHz clock and a byte-wide flash on a strobe-driven parallel bus.
package flash_host_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and timing
  localparam int          ADDR_W        = 19;
  localparam int          DATA_W        = 8;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          SECTOR_BYTES  = 256;
  localparam int          ERASE_SEC_MS  = 4;
  localparam int          ERASE_CHIP_MS = 20;
  localparam int          SECTOR_CYC    = CLK_HZ / 1000 * ERASE_SEC_MS;
  localparam int          CHIP_CYC      = CLK_HZ / 1000 * ERASE_CHIP_MS;
  localparam int          PHASE_CYC     = 2;
  localparam int          POLL_BIT      = 7;
  localparam int          ALT_BIT       = 6;
  localparam int          SEQ_LEN       = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0]  CMD_SEC_SETUP  = 8'h20;
  localparam logic [7:0]  CMD_SEC_EXEC   = 8'hD0;
  localparam logic [7:0]  CMD_CHIP_SETUP = 8'h30;
  localparam logic [7:0]  CMD_CHIP_EXEC  = 8'h30;
  localparam logic [7:0]  CMD_PROG_SETUP = 8'h10;
  localparam logic [7:0]  CMD_RESET      = 8'hFF;

  // Seven-read address lists; only the last entry differs
  localparam logic [ADDR_W-1:0] SEQ_ADDR [SEQ_LEN] = '{
    19'h0_1823, 19'h0_1820, 19'h0_1822, 19'h0_0418,
    19'h0_041B, 19'h0_0419, 19'h0_041A};
  localparam logic [ADDR_W-1:0] LOCK_LAST = 19'h0_040A;

  ////////////////////////////////////////////////////////////////////////////
  // Host operations
  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_SEC_ERASE, OP_CHIP_ERASE, OP_UNLOCK, OP_LOCK, OP_ABORT
  } op_e;

  typedef struct packed {
    op_e               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_s;

  // Flash pins as seen from the host; data is three-state
  typedef struct packed {
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe;
  } pins_s;

endpackage

// ### core/bus_cycle.sv
// Single flash bus cycle engine: one write or one read on the parallel pins.
// Assumes the caller holds start for one cycle and waits for done.
`timescale 1ns/1ps
module bus_cycle
  import flash_host_pkg::*;
#(
  parameter int PHASE = PHASE_CYC
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  // Cycle request
  input  wire logic                      start,
  input  wire logic                      is_write,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [DATA_W-1:0]         wdata,
  output logic                           done,
  output logic      [DATA_W-1:0]         rdata,
  // Synchronised read data
  input  wire logic [DATA_W-1:0]         dq_sync,
  // Pins
  output flash_host_pkg::pins_s          pins
);
  import flash_host_pkg::*;

  // Refuse strobe lengths the 8-bit phase counter cannot hold
  if (PHASE < 1 || PHASE > 255) begin : g_bad_phase
    $error("PHASE must lie between 1 and 255");
  end

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cyc_e;
  cyc_e                 st_r;
  logic [7:0]           cnt_r;
  logic                 wr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence: address and select first, then strobe, then release
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r  <= C_IDLE;
      cnt_r <= '0;
      wr_r  <= 1'b0;
      done  <= 1'b0;
      rdata <= '0;
      pins  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
    end else begin
      done <= 1'b0;
      unique case (st_r)
        C_IDLE: begin
          if (start) begin
            wr_r       <= is_write;
            pins.addr  <= addr;
            pins.dq_o  <= wdata;
            pins.dq_oe <= is_write;
            pins.ce_n  <= 1'b0;
            cnt_r      <= 8'(PHASE);
            st_r       <= C_SETUP;
          end
        end
        C_SETUP: begin
          // Strobe falls after select, so address is taken here
          pins.we_n <= ~wr_r;
          pins.oe_n <= wr_r;
          cnt_r     <= 8'(PHASE);
          st_r      <= C_STROBE;
        end
        C_STROBE: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            // Strobe rises first with data still driven
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            st_r      <= C_HOLD;
          end
        end
        C_HOLD: begin
          // Synchroniser lags the pins by two edges, so read data is taken here
          if (!wr_r) rdata <= dq_sync;
          pins.ce_n  <= 1'b1;
          pins.dq_oe <= 1'b0;
          done       <= 1'b1;
          st_r       <= C_IDLE;
        end
      endcase
    end
  end

endmodule

// ### core/flash_host.sv
// Host controller that drives the parallel flash through its pins.
// Assumes the flash sits directly on the pins and requests come from logic on mclk.
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int SEC_TIMEOUT  = SECTOR_CYC,
  parameter int CHIP_TIMEOUT = CHIP_CYC
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  // Request
  input  wire logic                      req_valid,
  output logic                           req_ready,
  input  wire flash_host_pkg::req_s      req,
  // Answer
  output logic                           rsp_valid,
  output logic      [DATA_W-1:0]         rsp_data,
  output logic                           rsp_timeout,
  output logic                           write_lock_state,
  output logic                           busy,
  // Flash pins
  output flash_host_pkg::pins_s          pins,
  input  wire logic [DATA_W-1:0]         dq_i
);
  import flash_host_pkg::*;

  // Refuse poll limits too short to cover even one status read
  if (SEC_TIMEOUT < 4 || CHIP_TIMEOUT < 4) begin : g_bad_timeout
    $error("SEC_TIMEOUT and CHIP_TIMEOUT must be at least 4");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_CMD1, S_CMD2, S_SEQ, S_POLL, S_DONE
  } st_e;

  st_e                  st_r;
  req_s                 cur_r;
  logic [2:0]           idx_r;
  logic [31:0]          tmo_r;
  logic [DATA_W-1:0]    dq_meta_r;
  logic [DATA_W-1:0]    dq_sync_r;
  logic [DATA_W-1:0]    prev_r;
  logic                 have_prev_r;
  logic                 cyc_start;
  logic                 cyc_wr;
  logic [ADDR_W-1:0]    cyc_addr;
  logic [DATA_W-1:0]    cyc_data;
  logic                 cyc_done;
  logic [DATA_W-1:0]    cyc_rdata;
  logic                 cyc_pend_r;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser on read data from the pins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dq_meta_r <= '0;
      dq_sync_r <= '0;
    end else begin
      dq_meta_r <= dq_i;
      dq_sync_r <= dq_meta_r;
    end
  end

  bus_cycle #(
    .PHASE    (PHASE_CYC)
  ) u_cycle (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .start    (cyc_start),
    .is_write (cyc_wr),
    .addr     (cyc_addr),
    .wdata    (cyc_data),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .dq_sync  (dq_sync_r),
    .pins     (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // One bus cycle in flight at a time; start waits for the previous done
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cyc_pend_r <= 1'b0;
    end else if (cyc_done) begin
      cyc_pend_r <= 1'b0;
    end else if (cyc_start) begin
      cyc_pend_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pick the bus cycle each state needs
  always_comb begin
    // One start pulse per bus cycle; held off while one is in flight
    cyc_start = (st_r inside {S_CMD1, S_CMD2, S_SEQ, S_POLL}) && !cyc_pend_r;
    cyc_wr    = 1'b1;
    cyc_addr  = cur_r.addr;
    cyc_data  = cur_r.data;
    unique case (st_r)
      S_CMD1: begin
        unique case (cur_r.op)
          OP_PROGRAM:    cyc_data = CMD_PROG_SETUP;
          OP_SEC_ERASE:  cyc_data = CMD_SEC_SETUP;
          OP_CHIP_ERASE: cyc_data = CMD_CHIP_SETUP;
          default:       cyc_data = CMD_RESET;
        endcase
      end
      S_CMD2: begin
        unique case (cur_r.op)
          OP_SEC_ERASE:  cyc_data = CMD_SEC_EXEC;
          OP_CHIP_ERASE: cyc_data = CMD_CHIP_EXEC;
          default:       cyc_data = cur_r.data;
        endcase
      end
      S_SEQ: begin
        cyc_wr   = 1'b0;
        cyc_addr = (idx_r == 3'(SEQ_LEN - 1) && cur_r.op == OP_LOCK)
                   ? LOCK_LAST : SEQ_ADDR[idx_r];
      end
      S_POLL: cyc_wr = 1'b0;
      default: cyc_start = 1'b0;
    endcase
  end

  // Handshake and status outputs
  assign req_ready = (st_r == S_IDLE);
  assign busy      = (st_r != S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r             <= S_IDLE;
      cur_r            <= '{op: OP_READ, addr: '0, data: '0};
      idx_r            <= '0;
      tmo_r            <= '0;
      prev_r           <= '0;
      have_prev_r      <= 1'b0;
      rsp_valid        <= 1'b0;
      rsp_data         <= '0;
      rsp_timeout      <= 1'b0;
      write_lock_state <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st_r)
        S_IDLE: begin
          if (req_valid) begin
            cur_r       <= req;
            idx_r       <= '0;
            rsp_timeout <= 1'b0;
            have_prev_r <= 1'b0;
            // Reads and lock sequences never need the part unlocked
            unique case (req.op)
              OP_READ:            st_r <= S_POLL;
              OP_UNLOCK, OP_LOCK: st_r <= S_SEQ;
              OP_ABORT:           st_r <= S_CMD1;
              default: begin
                // Locked part ignores writes; refuse here instead
                if (write_lock_state) begin
                  rsp_timeout <= 1'b1;
                  st_r        <= S_DONE;
                end else begin
                  st_r <= S_CMD1;
                end
              end
            endcase
          end
        end
        S_CMD1: if (cyc_done) begin
          // Abort stays unlocked or locked as it was
          st_r <= (cur_r.op == OP_ABORT) ? S_DONE : S_CMD2;
        end
        S_CMD2: if (cyc_done) begin
          // Sector address lies in upper bits; low byte ignored
          if (cur_r.op == OP_SEC_ERASE) begin
            tmo_r <= 32'(SEC_TIMEOUT);
          end else begin
            tmo_r <= 32'(CHIP_TIMEOUT);
          end
          st_r <= S_POLL;
        end
        S_SEQ: if (cyc_done) begin
          // Seventh read sets the host's copy of the lock state
          if (idx_r == 3'(SEQ_LEN - 1)) begin
            write_lock_state <= (cur_r.op == OP_LOCK);
            st_r             <= S_DONE;
          end else begin
            idx_r <= idx_r + 3'h1;
          end
        end
        S_POLL: begin
          // Poll limit counts down on every cycle of the loop
          if (tmo_r > 32'h0) tmo_r <= tmo_r - 32'h1;
          if (cyc_done) begin
            prev_r      <= cyc_rdata;
            have_prev_r <= 1'b1;
            if (cur_r.op == OP_READ) begin
              rsp_data <= cyc_rdata;
              st_r     <= S_DONE;
            end else if (have_prev_r
                         && prev_r[ALT_BIT] == cyc_rdata[ALT_BIT]
                         && (cur_r.op != OP_PROGRAM
                             || cyc_rdata[POLL_BIT] == cur_r.data[POLL_BIT])) begin
              rsp_data <= cyc_rdata;
              st_r     <= S_DONE;
            end else if (tmo_r == 32'h0) begin
              rsp_timeout <= 1'b1;
              st_r        <= S_DONE;
            end
          end
        end
        S_DONE: begin
          rsp_valid <= 1'b1;
          st_r      <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

endmodule

// ### dv/flash_device_model.sv
// Behavioural model of the byte-wide flash on the host's pins.
// Assumes the host package pins struct; the flash has no clock.
`timescale 1ns/1ps
module flash_device_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_NS = 3000
) (
  // Pins from the host
  input  wire flash_host_pkg::pins_s pins,
  // Data back and protection state
  output logic [DATA_W-1:0]          dq_i,
  output logic                       locked
);
  logic [7:0]  mem [int];
  logic [18:0] la;
  logic [7:0]  ld;
  logic [7:0]  dq_r;
  logic        tog;
  int          st;
  int          k;
  time         t_end;
  wire         wr = !pins.ce_n && !pins.we_n;
  wire         rd = !pins.ce_n && !pins.oe_n;

  // Erased bytes read as all ones
  function automatic logic [7:0] rdm(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  ////////////////////////////////////////
  // Power-up state
  initial begin
    locked = 1'b1;
    st = 0;
    k = 0;
    tog = 1'b0;
    t_end = 0;
    dq_r = 8'h00;
  end

  // Address at the later falling strobe
  always @(posedge wr) la = pins.addr;

  // Command decode at the first rising strobe
  always @(negedge wr) begin
    int s;
    s = st;
    st = 0;
    ld = pins.dq_o;
    if (ld == CMD_RESET) begin
      t_end = $time;
    end else if (s == 3) begin
      mem[int'(la)] = ld;
      t_end = $time + BUSY_NS;
    end else if (s == 1 && ld == CMD_SEC_EXEC) begin
      for (int i = 0; i < SECTOR_BYTES; i++)
        mem.delete(int'({la[18:8], 8'h00}) + i);
      t_end = $time + BUSY_NS;
    end else if (s == 2 && ld == CMD_CHIP_EXEC) begin
      mem.delete();
      t_end = $time + BUSY_NS;
    end else if (!locked) begin
      st = ld == CMD_SEC_SETUP ? 1 : ld == CMD_CHIP_SETUP ? 2 :
           ld == CMD_PROG_SETUP ? 3 : 0;
    end
  end

  // Status while busy, array data otherwise
  always @(posedge rd)
    dq_r = ($time < t_end) ? {~ld[7], tog, 6'h00} : rdm(int'(pins.addr));

  // A released bus shows the inverse of the last value
  always_comb dq_i = rd ? dq_r : ~dq_r;

  // Toggle and seven-read tracking at the read's rising strobe
  always @(negedge rd) begin
    if ($time < t_end)
      tog = ~tog;
    if (k == 6 && (pins.addr == SEQ_ADDR[6] || pins.addr == LOCK_LAST)) begin
      locked = (pins.addr == LOCK_LAST);
      k = 0;
    end else if (pins.addr == SEQ_ADDR[k])
      k++;
    else
      k = int'(pins.addr == SEQ_ADDR[0]);
  end
endmodule

// ### dv/flash_host_properties.sv
// Port checker for the flash host controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module flash_host_properties
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  // Request and answer
  input wire logic                  req_valid,
  input wire logic                  req_ready,
  input wire flash_host_pkg::req_s  req,
  input wire logic                  rsp_valid,
  input wire logic                  rsp_timeout,
  input wire logic                  write_lock_state,
  // Flash pins
  input wire flash_host_pkg::pins_s pins
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Locked write request, then a reply with no bus cycle
  sequence take_locked;
    req_valid && req_ready && write_lock_state &&
      req.op inside {OP_PROGRAM, OP_SEC_ERASE, OP_CHIP_ERASE};
  endsequence
  sequence quiet_refusal;
    ##1 pins.ce_n [*2] ##0 (rsp_valid && rsp_timeout);
  endsequence

  ////////////////////////////////////////
  a_locked_refused: assert property (take_locked |-> quiet_refusal)
    else $error("locked request not refused");
  a_strobe_select: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n && pins.dq_oe)
    else $error("write strobe without select or data");
  a_write_pulse: assert property ($fell(pins.we_n) |-> !pins.we_n [*2] ##[1:2] pins.we_n)
    else $error("write strobe length wrong");
  a_hold_stable: assert property (!pins.we_n && $past(!pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_o))
    else $error("address or data moved in strobe");
  a_select_frames: assert property ($rose(pins.ce_n) |-> $past(pins.we_n && pins.oe_n))
    else $error("select released before strobe");
  a_read_no_drive: assert property (!pins.oe_n |-> !pins.dq_oe && !pins.ce_n)
    else $error("host drives data during read");
  a_reset_state: assert property ($past(sys_rst) |-> pins.ce_n && write_lock_state && !rsp_valid)
    else $error("state after reset wrong");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse too long");
endmodule

bind flash_host flash_host_properties u_props (.mclk(mclk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
  .rsp_timeout(rsp_timeout), .write_lock_state(write_lock_state), .pins(pins));

// ### dv/parallel_flash_command_sequencer_tb.sv
// Testbench for the flash host controller against a flash model.
// Assumes short poll time-outs and a model busy time well inside them.
`timescale 1ns/1ps
module parallel_flash_command_sequencer_tb;
  import flash_host_pkg::*;
  logic              mclk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              req_valid = 1'b0;
  req_s              req = '0;
  logic              req_ready, rsp_valid, rsp_timeout, write_lock_state, busy, locked;
  logic [DATA_W-1:0] rsp_data, dq_i;
  pins_s             pins;
  int                num_errors = 0;
  int                num_checks = 0;

  always #50 mclk = ~mclk;

  flash_host #(.SEC_TIMEOUT(200), .CHIP_TIMEOUT(200)) DUT (.mclk(mclk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_timeout(rsp_timeout), .write_lock_state(write_lock_state),
    .busy(busy), .pins(pins), .dq_i(dq_i));
  flash_device_model #(.BUSY_NS(3000)) u_flash (.pins(pins), .dq_i(dq_i), .locked(locked));

  ////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One request, then wait for its answer
  task automatic run(input op_e o, input logic [18:0] a, input logic [7:0] d);
    int n;
    @(negedge mclk);
    req = '{o, a, d};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    chk({6'h00, busy, req_ready}, 8'h02);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    chk({5'h00, rsp_valid, busy, req_ready}, 8'h05);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // Locked after reset: program refused, array untouched
  task automatic t_locked;
    chk({6'h00, write_lock_state, pins.ce_n}, 8'h03);
    run(OP_PROGRAM, 19'h0_0123, 8'h5A);
    chk({7'h00, rsp_timeout}, 8'h01);
    run(OP_READ, 19'h0_0123, 8'h00);
    chk(rsp_data, 8'hFF);
  endtask

  // Unlock, program two bytes, neighbour stays erased
  task automatic t_program;
    run(OP_UNLOCK, 19'h0_0000, 8'h00);
    chk({6'h00, write_lock_state, locked}, 8'h00);
    run(OP_PROGRAM, 19'h0_0123, 8'h5A);
    chk({7'h00, rsp_timeout}, 8'h00);
    run(OP_PROGRAM, 19'h0_0201, 8'h3C);
    run(OP_READ, 19'h0_0123, 8'h00);
    chk(rsp_data, 8'h5A);
    run(OP_READ, 19'h0_0124, 8'h00);
    chk(rsp_data, 8'hFF);
  endtask

  // Sector erase at the sector's last byte, then whole array
  task automatic t_erase;
    run(OP_SEC_ERASE, 19'h0_01FF, 8'h00);
    chk({7'h00, rsp_timeout}, 8'h00);
    run(OP_READ, 19'h0_0123, 8'h00);
    chk(rsp_data, 8'hFF);
    run(OP_READ, 19'h0_0201, 8'h00);
    chk(rsp_data, 8'h3C);
    run(OP_CHIP_ERASE, 19'h0_0000, 8'h00);
    chk({7'h00, rsp_timeout}, 8'h00);
    run(OP_READ, 19'h0_0201, 8'h00);
    chk(rsp_data, 8'hFF);
  endtask

  // Abort keeps the lock state, then lock again
  task automatic t_abort_lock;
    run(OP_ABORT, 19'h0_0000, 8'h00);
    chk({6'h00, write_lock_state, locked}, 8'h00);
    run(OP_LOCK, 19'h0_0000, 8'h00);
    chk({6'h00, write_lock_state, locked}, 8'h03);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    t_locked;
    t_program;
    t_erase;
    t_abort_lock;
    final_report;
  end

  // Watchdog
  initial begin
    #5000000;
    $display("[ERR] %0t watchdog expired", $time);
    num_errors++;
    final_report;
  end
endmodule
